//--- hdl/flash_reset_params.svh
// constants for the software reset sequencer of the serial flash
// assumes the core clock runs at 125 MHz; link pins are asynchronous to it
// Notes on behaviour
// - accepted reset aborts work, restores defaults
// - reset clears all volatile settings
// - arm and execute work in both modes
// - execute only counts directly after arm
// - any other command disarms the sequence
// - no command accepted during recovery time
`ifndef FLASH_RESET_PARAMS_SVH
`define FLASH_RESET_PARAMS_SVH

`define OP_RESET_ARM 8'h66
`define OP_RESET_EXEC 8'h99
`define CLK_PERIOD_NS 8
`define RECOVERY_TIME_NS 30000
`define RECOVERY_CYCLES (`RECOVERY_TIME_NS / `CLK_PERIOD_NS)
`define STATUS_VOL_RESET 8'h00
`define READ_PARAM_RESET 8'h00
`define CONT_MODE_RESET 8'h00
`define WRAP_RESET 3'h7
`define WRAP_FIELD_HI 6
`define WRAP_FIELD_LO 4
`define BITS_PER_OP 3'h7
`define NIBBLES_PER_OP 3'h1

`endif

//--- hdl/flash_reset_pkg.sv
// types shared by the reset sequencer files
// assumes flash_reset_params.svh supplies the numeric constants
`default_nettype none
package flash_reset_pkg;
	typedef enum logic [1:0] {
		st_idle,
		st_armed,
		st_recover
	} reset_state_t;
endpackage
`default_nettype wire

//--- hdl/pin_sync.sv
// two-stage synchroniser for pins arriving from outside the core clock
// assumes the pins are quasi-static relative to 8 ns sampling
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// pins
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// first stage is read only by the second
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

//--- hdl/flash_reset_sequencer.sv
// software reset sequencer: decodes instruction bytes from the serial link,
// tracks the arm/execute pair and owns the volatile settings it must clear
// assumes the link clock is far slower than ref_clk_in (160 ns vs 8 ns)
`include "flash_reset_params.svh"
`default_nettype none
module flash_reset_sequencer #(
	parameter int RECOVERY_CYCLES = `RECOVERY_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// serial link from the host
	input wire logic link_clk_in,
	input wire logic chip_sel_n_in,
	input wire logic [3:0] link_io_in,
	// mode and volatile setting controls from the rest of the device
	input wire logic quad_lane_instruction_mode_in,
	input wire logic busy_in,
	input wire logic set_write_enable_in,
	input wire logic set_paused_in,
	input wire logic load_read_param_in,
	input wire logic load_cont_mode_in,
	input wire logic load_wrap_in,
	input wire logic [7:0] setting_data_in,
	input wire logic [7:0] status_vol_d_in,
	input wire logic load_status_vol_in,
	// status towards the rest of the device
	output logic reset_armed_out,
	output logic recovering_out,
	output logic abort_ops_out,
	output logic cmd_valid_out,
	output logic [7:0] cmd_byte_out,
	output logic write_enable_latch_out,
	output logic paused_operation_flag_out,
	output logic [7:0] read_parameter_bits_out,
	output logic [7:0] continuous_read_mode_bits_out,
	output logic [2:0] wrap_setting_bits_out,
	output logic [7:0] status_vol_out
);
	localparam int CNT_W = $clog2(RECOVERY_CYCLES + 1);

	logic [5:0] pins_s;
	logic clk_s, cs_n_s, clk_prev_q;
	logic [3:0] io_s;
	logic rise;
	logic [7:0] shift_q;
	logic [2:0] cnt_q;
	logic frame_done_q;
	logic op_done;
	logic [7:0] op_byte;
	flash_reset_pkg::reset_state_t state_q;
	logic [CNT_W-1:0] rec_q;
	logic accept;
	logic arm_hit;
	logic exec_hit;

	// compare a decoded byte with one opcode; the tracker and the abort pulse share it
	function automatic logic op_is(input logic [7:0] got, input logic [7:0] code);
		op_is = (got == code);
	endfunction

	// shift one bit or one nibble into the instruction byte
	function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic quad,
		input logic [3:0] io);
		shift_in = quad ? {cur[3:0], io} : {cur[6:0], io[0]};
	endfunction

	// pins are asynchronous, so everything goes through two flops
	// the chip select stage resets to selected; harmless, since the clock stage
	// resets low and no rising edge can be seen until a real one arrives
	pin_sync #(.WIDTH(6)) u_sync (
		.clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.async_in({link_clk_in, chip_sel_n_in, link_io_in}),
		.sync_out(pins_s)
	);
	assign clk_s = pins_s[5];
	assign cs_n_s = pins_s[4];
	assign io_s = pins_s[3:0];
	assign rise = clk_s & ~clk_prev_q & ~cs_n_s;

	// edge detector on the synchronised link clock
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			clk_prev_q <= 1'b0;
		end else begin
			clk_prev_q <= clk_s;
		end
	end

	// only the first byte of a frame is the instruction; both widths decode
	assign op_byte = shift_in(shift_q, quad_lane_instruction_mode_in, io_s);
	assign op_done = rise && !frame_done_q &&
		(cnt_q == (quad_lane_instruction_mode_in ? `NIBBLES_PER_OP : `BITS_PER_OP));
	// commands arriving while recovering are dropped entirely, not queued
	assign accept = op_done && (state_q != flash_reset_pkg::st_recover);
	// opcode hits on an accepted byte only, so refused bytes never arm or execute
	assign arm_hit = accept && op_is(op_byte, `OP_RESET_ARM);
	assign exec_hit = accept && op_is(op_byte, `OP_RESET_EXEC);

	// instruction shifter, restarted by every chip select
	// bits past the first byte are ignored, so address or data never decode as opcodes
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			shift_q <= 8'h00;
			cnt_q <= 3'h0;
			frame_done_q <= 1'b0;
		end else if (cs_n_s) begin
			cnt_q <= 3'h0;
			frame_done_q <= 1'b0;
		end else if (rise && !frame_done_q) begin
			shift_q <= op_byte;
			cnt_q <= cnt_q + 3'h1;
			frame_done_q <= op_done;
		end
	end

	// hand decoded instructions to the rest of the device
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cmd_valid_out <= 1'b0;
			cmd_byte_out <= 8'h00;
		end else begin
			cmd_valid_out <= accept;
			if (accept) begin
				cmd_byte_out <= op_byte;
			end
		end
	end

	// arm/execute tracking; an execute takes effect only right after arm
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q <= flash_reset_pkg::st_idle;
			rec_q <= '0;
		end else begin
			case (state_q)
				flash_reset_pkg::st_idle: begin
					if (arm_hit) begin
						state_q <= flash_reset_pkg::st_armed;
					end
				end
				flash_reset_pkg::st_armed: begin
					if (exec_hit) begin
						state_q <= flash_reset_pkg::st_recover;
						rec_q <= CNT_W'(RECOVERY_CYCLES - 1);
					end else if (accept && !arm_hit) begin
						state_q <= flash_reset_pkg::st_idle;
					end
				end
				flash_reset_pkg::st_recover: begin
					// leaves disarmed, so a lone execute afterwards does nothing
					if (rec_q == '0) begin
						state_q <= flash_reset_pkg::st_idle;
					end else begin
						rec_q <= rec_q - CNT_W'(1);
					end
				end
				default: begin
					state_q <= flash_reset_pkg::st_idle;
				end
			endcase
		end
	end

	// status outputs, registered for clean timing
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			reset_armed_out <= 1'b0;
			recovering_out <= 1'b0;
			abort_ops_out <= 1'b0;
		end else begin
			reset_armed_out <= (state_q == flash_reset_pkg::st_armed);
			recovering_out <= (state_q == flash_reset_pkg::st_recover);
			// one pulse that aborts program/erase; busy_in is not consulted
			// because that check belongs to the host
			abort_ops_out <= (state_q == flash_reset_pkg::st_armed) && exec_hit;
		end
	end

	// volatile settings: cleared on power-up and throughout recovery
	// a set strobe landing during recovery is lost: the clear wins, because the
	// device accepts nothing until recovery ends
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			write_enable_latch_out <= 1'b0;
			paused_operation_flag_out <= 1'b0;
			read_parameter_bits_out <= `READ_PARAM_RESET;
			continuous_read_mode_bits_out <= `CONT_MODE_RESET;
			wrap_setting_bits_out <= `WRAP_RESET;
			status_vol_out <= `STATUS_VOL_RESET;
		end else if (state_q == flash_reset_pkg::st_recover) begin
			write_enable_latch_out <= 1'b0;
			paused_operation_flag_out <= 1'b0;
			read_parameter_bits_out <= `READ_PARAM_RESET;
			continuous_read_mode_bits_out <= `CONT_MODE_RESET;
			wrap_setting_bits_out <= `WRAP_RESET;
			status_vol_out <= `STATUS_VOL_RESET;
		end else begin
			if (set_write_enable_in) begin
				write_enable_latch_out <= 1'b1;
			end
			if (set_paused_in && busy_in) begin
				paused_operation_flag_out <= 1'b1;
			end
			if (load_read_param_in) begin
				read_parameter_bits_out <= setting_data_in;
			end
			if (load_cont_mode_in) begin
				continuous_read_mode_bits_out <= setting_data_in;
			end
			if (load_wrap_in) begin
				wrap_setting_bits_out <= setting_data_in[`WRAP_FIELD_HI:`WRAP_FIELD_LO];
			end
			if (load_status_vol_in) begin
				status_vol_out <= status_vol_d_in;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/flash_reset_sequencer_assertions.sv
// port checker for the software reset sequencer
// assumes one clock domain and binding to flash_reset_sequencer
`default_nettype none
module flash_reset_sequencer_assertions #(
	parameter int RECOVERY_CYCLES = 3750
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// watched outputs
	input wire logic reset_armed_out,
	input wire logic recovering_out,
	input wire logic abort_ops_out,
	input wire logic cmd_valid_out,
	input wire logic [7:0] cmd_byte_out,
	input wire logic write_enable_latch_out,
	input wire logic [2:0] wrap_setting_bits_out
);
	int rec_q;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	// cycles spent recovering; too long for a repetition count
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			rec_q <= 0;
		else
			rec_q <= recovering_out ? rec_q + 1 : 0;
	end
	sequence arm_seen;
		cmd_valid_out && cmd_byte_out == 8'h66;
	endsequence
	sequence other_seen;
		cmd_valid_out && cmd_byte_out != 8'h66;
	endsequence
	sequence exec_armed;
		cmd_valid_out && cmd_byte_out == 8'h99 && reset_armed_out;
	endsequence
	sequence exec_lone;
		cmd_valid_out && cmd_byte_out == 8'h99 && !reset_armed_out;
	endsequence
	// abort pulse with the command, then recovery with the arm dropped
	sequence recover_entry;
		abort_ops_out ##1 (recovering_out && !reset_armed_out);
	endsequence
	// second and later recovery cycles, once the clears have landed
	sequence deep_recovery;
		recovering_out && $past(recovering_out);
	endsequence
	sequence at_defaults;
		!write_enable_latch_out && wrap_setting_bits_out == 3'h7;
	endsequence
	arm_sets_a: assert property (arm_seen |=> reset_armed_out)
		else $error("arm opcode did not arm");
	exec_resets_a: assert property (exec_armed |-> recover_entry)
		else $error("execute after arm did not reset");
	other_disarms_a: assert property (other_seen |=> !reset_armed_out)
		else $error("other opcode left the sequence armed");
	lone_exec_a: assert property (exec_lone |-> !abort_ops_out)
		else $error("lone execute caused a reset");
	abort_cause_a: assert property (abort_ops_out |-> exec_armed)
		else $error("abort without an armed execute");
	recover_refuse_a: assert property (recovering_out |-> !cmd_valid_out)
		else $error("command accepted while recovering");
	settings_clear_a: assert property (deep_recovery |-> at_defaults)
		else $error("volatile settings not at defaults");
	recover_len_a: assert property ($fell(recovering_out) |-> rec_q == RECOVERY_CYCLES)
		else $error("recovery span has the wrong length");
endmodule
bind flash_reset_sequencer flash_reset_sequencer_assertions #(
	.RECOVERY_CYCLES(RECOVERY_CYCLES)) chk (.ref_clk_in, .resetn_in, .reset_armed_out,
	.recovering_out, .abort_ops_out, .cmd_valid_out, .cmd_byte_out,
	.write_enable_latch_out, .wrap_setting_bits_out);
`default_nettype wire

//--- tb/flash_host_model.sv
// host side of the serial link: sends one instruction a frame
// assumes an 8 ns clock; link clock 160 ns, low and still between frames
`default_nettype none
module flash_host_model (
	// bench clock
	input wire logic clk_in,
	// link towards the device
	output logic link_clk_out,
	output logic chip_sel_n_out,
	output logic [3:0] link_io_out
);
	timeunit 1ns/1ps;
	bit powered = 1'b0;
	initial begin
		link_clk_out = 1'b0;
		chip_sel_n_out = 1'b1;
		link_io_out = 4'h0;
	end
	task automatic half();
		repeat (10) @(posedge clk_in);
	endtask
	// n units msb first; only reset and plain opcodes, never a write
	task automatic send(input logic [7:0] op, input int n, input logic quad);
		if (!powered)
			repeat (2500) @(posedge clk_in);
		powered = 1'b1;
		chip_sel_n_out <= 1'b0;
		for (int i = 0; i < n; i++) begin
			link_io_out <= quad ? op[7-4*i -: 4] : {~link_io_out[3:1], op[7-i]};
			half();
			link_clk_out <= 1'b1;
			half();
			link_clk_out <= 1'b0;
		end
		half();
		chip_sel_n_out <= 1'b1;
		link_io_out <= ~link_io_out; // released lanes must not keep the last bit
		half();
	endtask
endmodule
`default_nettype wire

//--- tb/test_flash_reset_sequencer.sv
// self-checking bench for the software reset sequencer
// assumes flash_host_model on the link and the checker bound to uut
`default_nettype none
module test_flash_reset_sequencer;
	timeunit 1ns/1ps;
	localparam int REC = 400;
	localparam logic [31:0] DEFAULTS = {3'h0, 1'b0, 1'b0, 8'h00, 8'h00, 3'h7, 8'h00};
	localparam logic [31:0] LOADED = {3'h0, 1'b1, 1'b1, 8'h5a, 8'h5a, 3'h5, 8'h3c};
	logic ref_clk_in = 0, resetn_in = 0, quad_lane_instruction_mode_in = 0, busy_in = 0;
	logic set_write_enable_in = 0, set_paused_in = 0, load_read_param_in = 0;
	logic load_cont_mode_in = 0, load_wrap_in = 0, load_status_vol_in = 0;
	logic [7:0] setting_data_in = 8'h5a, status_vol_d_in = 8'h3c, cmd_byte_out;
	logic link_clk_in, chip_sel_n_in, reset_armed_out, recovering_out, abort_ops_out;
	logic cmd_valid_out, write_enable_latch_out, paused_operation_flag_out;
	logic [3:0] link_io_in;
	logic [7:0] read_parameter_bits_out, continuous_read_mode_bits_out, status_vol_out;
	logic [2:0] wrap_setting_bits_out;
	int err_count = 0, total_checks = 0, n_cmd = 0, n_abort = 0;
	wire logic [31:0] vol = {3'h0, paused_operation_flag_out, write_enable_latch_out,
		read_parameter_bits_out, continuous_read_mode_bits_out, wrap_setting_bits_out,
		status_vol_out};
	flash_reset_sequencer #(.RECOVERY_CYCLES(REC)) uut (.ref_clk_in, .resetn_in,
		.link_clk_in, .chip_sel_n_in, .link_io_in, .quad_lane_instruction_mode_in,
		.busy_in, .set_write_enable_in, .set_paused_in, .load_read_param_in,
		.load_cont_mode_in, .load_wrap_in, .setting_data_in, .status_vol_d_in,
		.load_status_vol_in, .reset_armed_out, .recovering_out, .abort_ops_out,
		.cmd_valid_out, .cmd_byte_out, .write_enable_latch_out, .paused_operation_flag_out,
		.read_parameter_bits_out, .continuous_read_mode_bits_out, .wrap_setting_bits_out,
		.status_vol_out);
	flash_host_model host (.clk_in(ref_clk_in), .link_clk_out(link_clk_in),
		.chip_sel_n_out(chip_sel_n_in), .link_io_out(link_io_in));
	initial begin
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	// pulse counters, so one-cycle outputs are never missed
	always @(posedge ref_clk_in) begin
		if (cmd_valid_out === 1'b1) n_cmd <= n_cmd + 1;
		if (abort_ops_out === 1'b1) n_abort <= n_abort + 1;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one-cycle pulse of busy and the setting strobes
	task automatic load(input logic [6:0] v);
		@(posedge ref_clk_in);
		{busy_in, set_write_enable_in, set_paused_in, load_read_param_in, load_cont_mode_in,
			load_wrap_in, load_status_vol_in} <= v;
		@(posedge ref_clk_in);
		{busy_in, set_write_enable_in, set_paused_in, load_read_param_in, load_cont_mode_in,
			load_wrap_in, load_status_vol_in} <= 7'h00; // busy clear before a sequence
	endtask
	task automatic test_done();
		if (err_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		cmp(vol, DEFAULTS);
		cmp(reset_armed_out, 0);
		// pause strobe without busy must not set the flag
		load(7'h10);
		repeat (2) @(posedge ref_clk_in);
		cmp(vol, DEFAULTS);
		load(7'h7f);
		host.send(8'h99, 8, 1'b0);
		cmp(n_abort, 0);
		cmp(vol, LOADED);
		host.send(8'h66, 8, 1'b0);
		cmp(reset_armed_out, 1);
		// a cut frame is no command, so it leaves the arm standing
		host.send(8'h03, 4, 1'b0);
		cmp(reset_armed_out, 1);
		host.send(8'h03, 8, 1'b0);
		cmp(reset_armed_out, 0);
		cmp(cmd_byte_out, 8'h03);
		host.send(8'h99, 8, 1'b0);
		cmp(n_abort, 0);
		// spi then quad-lane: arm twice, execute, then try during recovery
		for (int m = 0; m < 2; m++) begin
			quad_lane_instruction_mode_in <= m[0];
			load(7'h7f);
			host.send(8'h66, m[0] ? 2 : 8, m[0]);
			host.send(8'h66, m[0] ? 2 : 8, m[0]);
			host.send(8'h99, m[0] ? 2 : 8, m[0]);
			cmp(n_abort, m + 1);
			cmp(recovering_out, 1);
			load(7'h20);
			host.send(8'h66, m[0] ? 2 : 8, m[0]);
			cmp(n_cmd, 7 + 3 * m);
			cmp(cmd_byte_out, 8'h99);
			for (int i = 0; i < REC + 50 && recovering_out; i++) @(posedge ref_clk_in);
			cmp(recovering_out, 0);
			cmp(vol, DEFAULTS);
			cmp(reset_armed_out, 0);
		end
		test_done();
	end
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		err_count++;
		test_done();
	end
endmodule
`default_nettype wire
